/* File: verilog/dtr_router.sv */
`timescale 1ns/1ps
module dtr_router #(
    parameter int N_AUX_IN  = 6,
    parameter int N_AUX_OUT = 3
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [N_AUX_IN-1:0]  aux_input_pin_i,
    input  wire logic                 counter_one_clock_in_i,
    input  wire logic                 counter_one_gate_in_i,
    input  wire logic                 counter_two_clock_in_i,
    input  wire logic                 counter_two_gate_in_i,
    output logic [N_AUX_OUT-1:0]      aux_output_pin_o,
    output logic                      adc_convert_o,
    output logic                      dac_update_o,
    output logic                      counter_one_output_o,
    output logic                      counter_two_output_o
);
    localparam int NS = N_AUX_IN + 4;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic [15:0]          ctrl;
        logic [17:0]          insel;
        logic [8:0]           outsel;
        logic [23:0]          adiv;
        logic [7:0]           slen;
        logic [15:0]          scnt;
        logic [23:0]          ddiv;
        logic [15:0]          ccfg;
        logic [1:0][15:0]     cload;
        logic [NS-1:0]        s1;
        logic [NS-1:0]        s2;
        logic [NS-1:0]        s3;
        dtr_pkg::dtr_adc_st_t ast;
        dtr_pkg::dtr_dac_st_t dst;
        logic [23:0]          apace;
        logic [23:0]          dpace;
        logic [7:0]           chan;
        logic                 last;
        logic [15:0]          scans;
        logic [3:0]           sb_cnt;
        logic [3:0]           ad_cnt;
        logic [3:0]           dt_cnt;
        logic [3:0]           du_cnt;
        logic [3:0]           cv_cnt;
        logic                 conv;
        logic                 upd;
        logic [9:0]           fdiv;
        logic [9:0]           sdiv;
        logic [1:0][15:0]     cnt;
        logic [1:0][15:0]     clatch;
        logic [1:0]           cout;
        logic [N_AUX_OUT-1:0] aout;
    } dtr_state_t;

    dtr_state_t q, d;

    // pick one synchronised aux input by a 3-bit field, apply polarity
    function automatic logic pick(input logic [NS-1:0] s, input logic [2:0] idx,
                                  input logic inv);
        // unused indices read inactive whatever the polarity, so a stray gate cannot block
        pick = (32'(idx) < N_AUX_IN) ? (s[idx] ^ inv) : 1'b0;
    endfunction

    logic        req, wr;
    logic [31:0] rd, wm, wv;
    logic        conv_e, gate_a, atb_e, dtrg_e, dupd_e, dtb_e;
    logic        atick, dtick, areq, dreq, ftick, stick, ce, g, gp;

    always_comb begin
        d   = q;
        req = wb_cyc_i && wb_stb_i && !q.ack;
        wr  = req && wb_we_i;
        rd  = 32'h0000_0000;
        unique case (wb_adr_i)
            dtr_pkg::OFS_CTRL:   rd = {16'h0000, q.ctrl};
            dtr_pkg::OFS_INSEL:  rd = {14'h0000, q.insel};
            dtr_pkg::OFS_OUTSEL: rd = {23'h000000, q.outsel};
            dtr_pkg::OFS_ADIV:   rd = {8'h00, q.adiv};
            dtr_pkg::OFS_SLEN:   rd = {24'h000000, q.slen};
            dtr_pkg::OFS_SCNT:   rd = {16'h0000, q.scnt};
            dtr_pkg::OFS_DDIV:   rd = {8'h00, q.ddiv};
            dtr_pkg::OFS_CCFG:   rd = {16'h0000, q.ccfg};
            dtr_pkg::OFS_CLOAD:  rd = q.cload;
            dtr_pkg::OFS_CLATCH: rd = q.clatch;
            dtr_pkg::OFS_STAT:   rd = {20'h00000, q.cout, q.dst, q.ast, 1'b0, q.chan[0],
                                       q.last, q.ast == dtr_pkg::AS_SCAN};
            default:             rd = 32'h0000_0000;
        endcase
        wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wv = (rd & ~wm) | (wb_dat_i & wm);
        d.ack  = req;
        d.rdat = rd;
        if (wr) begin
            unique case (wb_adr_i)
                dtr_pkg::OFS_CTRL:   d.ctrl = wv[15:0];
                dtr_pkg::OFS_INSEL:  d.insel = wv[17:0];
                dtr_pkg::OFS_OUTSEL: d.outsel = wv[8:0];
                dtr_pkg::OFS_ADIV:   d.adiv = wv[23:0];
                dtr_pkg::OFS_SLEN:   d.slen = wv[7:0];
                dtr_pkg::OFS_SCNT:   d.scnt = wv[15:0];
                dtr_pkg::OFS_DDIV:   d.ddiv = wv[23:0];
                dtr_pkg::OFS_CCFG:   d.ccfg = wv[15:0];
                dtr_pkg::OFS_CLOAD:  d.cload = wv;
                default:             d.rdat = rd;
            endcase
        end
        // self-clearing command bits never stored
        d.ctrl[dtr_pkg::C_ASTART] = 1'b0;
        d.ctrl[dtr_pkg::C_DARM]   = 1'b0;

        // two-stage sync, third stage only for edges
        d.s1 = {counter_two_gate_in_i, counter_one_gate_in_i,
                counter_two_clock_in_i, counter_one_clock_in_i, aux_input_pin_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        // convert strobe pin, default input zero
        conv_e = pick(q.s2, q.insel[dtr_pkg::I_CONV +: 3], q.ctrl[dtr_pkg::C_CONVPOL])
               & ~pick(q.s3, q.insel[dtr_pkg::I_CONV +: 3], q.ctrl[dtr_pkg::C_CONVPOL]);
        gate_a = pick(q.s2, q.insel[dtr_pkg::I_GATE +: 3], q.ctrl[dtr_pkg::C_GATEPOL]);
        atb_e  = pick(q.s2, q.insel[dtr_pkg::I_ATB +: 3], q.ctrl[dtr_pkg::C_ATBPOL])
               & ~pick(q.s3, q.insel[dtr_pkg::I_ATB +: 3], q.ctrl[dtr_pkg::C_ATBPOL]);
        dtrg_e = pick(q.s2, q.insel[dtr_pkg::I_DTRG +: 3], q.ctrl[dtr_pkg::C_DTRGPOL])
               & ~pick(q.s3, q.insel[dtr_pkg::I_DTRG +: 3], q.ctrl[dtr_pkg::C_DTRGPOL]);
        dupd_e = pick(q.s2, q.insel[dtr_pkg::I_DUPD +: 3], q.ctrl[dtr_pkg::C_DUPDPOL])
               & ~pick(q.s3, q.insel[dtr_pkg::I_DUPD +: 3], q.ctrl[dtr_pkg::C_DUPDPOL]);
        dtb_e  = pick(q.s2, q.insel[dtr_pkg::I_DTB +: 3], q.ctrl[dtr_pkg::C_DTBPOL])
               & ~pick(q.s3, q.insel[dtr_pkg::I_DTB +: 3], q.ctrl[dtr_pkg::C_DTBPOL]);

        // pulse stretchers count down to zero
        d.sb_cnt = (q.sb_cnt != 4'h0) ? q.sb_cnt - 4'h1 : 4'h0;
        d.ad_cnt = (q.ad_cnt != 4'h0) ? q.ad_cnt - 4'h1 : 4'h0;
        d.dt_cnt = (q.dt_cnt != 4'h0) ? q.dt_cnt - 4'h1 : 4'h0;
        d.du_cnt = (q.du_cnt != 4'h0) ? q.du_cnt - 4'h1 : 4'h0;
        d.cv_cnt = (q.cv_cnt != 4'h0) ? q.cv_cnt - 4'h1 : 4'h0;
        d.conv   = 1'b0;
        d.upd    = 1'b0;

        // pacer tick from internal clock or external timebase edge
        atick = q.ctrl[dtr_pkg::C_ATBEXT] ? atb_e : 1'b1;
        areq  = 1'b0;
        if (q.ast == dtr_pkg::AS_OFF) begin
            d.apace = q.adiv;
        end else if (q.ctrl[dtr_pkg::C_EXTCONV]) begin
            // external strobe on the chosen edge
            areq = conv_e;
        end else if (atick) begin
            areq    = (q.apace == 24'h000000);
            d.apace = areq ? q.adiv : q.apace - 24'h000001;
        end

        unique case (q.ast)
            dtr_pkg::AS_OFF: begin
                if (wr && wb_adr_i == dtr_pkg::OFS_CTRL && wv[dtr_pkg::C_ASTART]) begin
                    d.ast   = dtr_pkg::AS_WAIT;
                    d.scans = q.scnt;
                end
            end
            dtr_pkg::AS_WAIT: begin
                // gate blocks only the start of a scan
                if (areq && q.ctrl[dtr_pkg::C_RUN] && !gate_a) begin
                    d.ast    = dtr_pkg::AS_SCAN;
                    d.sb_cnt = dtr_pkg::EDGE_PULSE_CYC;
                    d.conv   = 1'b1;
                    d.cv_cnt = dtr_pkg::EDGE_PULSE_CYC;
                    d.chan   = q.slen - 8'h01;
                    d.last   = (q.slen <= 8'h01);
                end
            end
            dtr_pkg::AS_SCAN: begin
                if (q.last) begin
                    // hold drops one cycle after the last convert began
                    d.last = 1'b0;
                    d.ast  = dtr_pkg::AS_WAIT;
                    if (q.scans != 16'h0000) begin
                        d.scans = q.scans - 16'h0001;
                        if (q.scans == 16'h0001) begin
                            d.ast    = dtr_pkg::AS_OFF;
                            d.ad_cnt = dtr_pkg::EDGE_PULSE_CYC;
                        end
                    end
                end else if (areq) begin
                    d.conv   = 1'b1;
                    d.cv_cnt = dtr_pkg::EDGE_PULSE_CYC;
                    d.chan   = q.chan - 8'h01;
                    d.last   = (q.chan == 8'h01);
                end
            end
            default: d.ast = dtr_pkg::AS_OFF;
        endcase

        dtick = q.ctrl[dtr_pkg::C_DTBEXT] ? dtb_e : 1'b1;
        dreq  = 1'b0;
        if (q.dst != dtr_pkg::DS_RUN) begin
            d.dpace = q.ddiv;
        end else if (q.ctrl[dtr_pkg::C_DEXTUPD]) begin
            dreq = dupd_e;
        end else if (dtick) begin
            dreq    = (q.dpace == 24'h000000);
            d.dpace = dreq ? q.ddiv : q.dpace - 24'h000001;
        end
        unique case (q.dst)
            dtr_pkg::DS_OFF: begin
                if (wr && wb_adr_i == dtr_pkg::OFS_CTRL && wv[dtr_pkg::C_DARM]) begin
                    d.dst = dtr_pkg::DS_ARMED;
                end
            end
            dtr_pkg::DS_ARMED: begin
                // updates held off until trigger edge
                if (dtrg_e) begin
                    d.dst    = dtr_pkg::DS_RUN;
                    d.dt_cnt = dtr_pkg::EDGE_PULSE_CYC;
                end
            end
            dtr_pkg::DS_RUN: begin
                if (dreq) begin
                    d.upd    = 1'b1;
                    d.du_cnt = dtr_pkg::UPD_PULSE_CYC;
                end
            end
            default: d.dst = dtr_pkg::DS_OFF;
        endcase
        // new enable value, so enable and arm may share one write
        if (!d.ctrl[dtr_pkg::C_DEN]) begin
            d.dst = dtr_pkg::DS_OFF;
        end

        // on-board counter clock enables
        ftick  = (q.fdiv == dtr_pkg::FAST_DIV - 10'h001);
        stick  = (q.sdiv == dtr_pkg::SLOW_DIV - 10'h001);
        d.fdiv = ftick ? 10'h000 : q.fdiv + 10'h001;
        d.sdiv = stick ? 10'h000 : q.sdiv + 10'h001;
        ce = 1'b0;
        g  = 1'b0;
        gp = 1'b0;
        for (int i = 0; i < 2; i++) begin
            unique case (q.ccfg[8*i + dtr_pkg::K_SRC +: 2])
                dtr_pkg::SRC_FAST: ce = ftick;
                dtr_pkg::SRC_SLOW: ce = stick;
                default: ce = (q.s2[N_AUX_IN + i] ^ q.ccfg[8*i + dtr_pkg::K_CPOL])
                            & ~(q.s3[N_AUX_IN + i] ^ q.ccfg[8*i + dtr_pkg::K_CPOL]);
            endcase
            // gate polarity, count enable and latch
            g  = q.s2[N_AUX_IN + 2 + i] ^ q.ccfg[8*i + dtr_pkg::K_GPOL];
            gp = q.s3[N_AUX_IN + 2 + i] ^ q.ccfg[8*i + dtr_pkg::K_GPOL];
            if (g && !gp) begin
                d.clatch[i] = q.cnt[i];
            end
            // mode 0 terminal count, mode 2 rate generator
            if (wr && wb_adr_i == dtr_pkg::OFS_CLOAD && wb_sel_i[2*i]) begin
                d.cnt[i]  = wv[16*i +: 16];
                d.cout[i] = q.ccfg[8*i + dtr_pkg::K_MODE2];
            end else if (q.ccfg[8*i + dtr_pkg::K_MODE2]) begin
                if (!g) begin
                    d.cout[i] = 1'b1;
                end
                if (g && !gp) begin
                    d.cnt[i] = q.cload[i];
                end else if (g && ce) begin
                    if (q.cnt[i] <= 16'h0001) begin
                        d.cnt[i]  = q.cload[i];
                        d.cout[i] = 1'b1;
                    end else begin
                        d.cnt[i]  = q.cnt[i] - 16'h0001;
                        d.cout[i] = (q.cnt[i] != 16'h0002);
                    end
                end
            end else if (g && ce && q.cnt[i] != 16'h0000) begin
                d.cnt[i] = q.cnt[i] - 16'h0001;
                if (q.cnt[i] == 16'h0001) begin
                    d.cout[i] = 1'b1;
                end
            end
        end

        // each aux output shows one chosen signal
        for (int k = 0; k < N_AUX_OUT; k++) begin
            unique case (q.outsel[3*k +: 3])
                dtr_pkg::OS_SCAN_BEGIN: d.aout[k] = (d.sb_cnt != 4'h0);
                dtr_pkg::OS_SCAN_HOLD:  d.aout[k] = (d.ast == dtr_pkg::AS_SCAN)
                                                  ^ q.ctrl[dtr_pkg::C_HOLDPOL];
                dtr_pkg::OS_ACQ_DONE:   d.aout[k] = (d.ad_cnt != 4'h0);
                dtr_pkg::OS_CONVERT:    d.aout[k] = (d.cv_cnt != 4'h0);
                dtr_pkg::OS_DAC_TRIG:   d.aout[k] = (d.dt_cnt != 4'h0);
                dtr_pkg::OS_DAC_UPD:    d.aout[k] = (d.du_cnt != 4'h0)
                                                  ^ q.ctrl[dtr_pkg::C_DOUTPOL];
                default:                d.aout[k] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q        <= '0;
            q.ctrl   <= dtr_pkg::CTRL_RST;
            q.insel  <= dtr_pkg::INSEL_RST;
            q.outsel <= dtr_pkg::OUTSEL_RST;
            q.slen   <= dtr_pkg::SLEN_RST;
            q.ast    <= dtr_pkg::AS_OFF;
            q.dst    <= dtr_pkg::DS_OFF;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o             = q.rdat;
    assign wb_ack_o             = q.ack;
    assign aux_output_pin_o     = q.aout;
    assign adc_convert_o        = q.conv;
    assign dac_update_o         = q.upd;
    assign counter_one_output_o = q.cout[0];
    assign counter_two_output_o = q.cout[1];
endmodule

/* File: verilog/dtr_pkg.sv */
package dtr_pkg;
    localparam int CLK_HZ        = 40_000_000;
    localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int EDGE_PULSE_NS = 50;
    localparam int UPD_PULSE_NS  = 225;
    localparam int FAST_HZ       = 10_000_000;
    localparam int SLOW_HZ       = 100_000;
    localparam logic [3:0] EDGE_PULSE_CYC = 4'((EDGE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] UPD_PULSE_CYC  = 4'((UPD_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] FAST_DIV       = 10'(CLK_HZ / FAST_HZ);
    localparam logic [9:0] SLOW_DIV       = 10'(CLK_HZ / SLOW_HZ);

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_INSEL  = 8'h04;
    localparam logic [7:0] OFS_OUTSEL = 8'h08;
    localparam logic [7:0] OFS_ADIV   = 8'h0C;
    localparam logic [7:0] OFS_SLEN   = 8'h10;
    localparam logic [7:0] OFS_SCNT   = 8'h14;
    localparam logic [7:0] OFS_DDIV   = 8'h18;
    localparam logic [7:0] OFS_CCFG   = 8'h1C;
    localparam logic [7:0] OFS_CLOAD  = 8'h20;
    localparam logic [7:0] OFS_CLATCH = 8'h24;
    localparam logic [7:0] OFS_STAT   = 8'h28;

    // control bits
    localparam int C_RUN = 0, C_EXTCONV = 1, C_CONVPOL = 2, C_GATEPOL = 3;
    localparam int C_ATBEXT = 4, C_ATBPOL = 5, C_DTRGPOL = 6, C_DUPDPOL = 7;
    localparam int C_DTBEXT = 8, C_DTBPOL = 9, C_DOUTPOL = 10, C_HOLDPOL = 11;
    localparam int C_DEXTUPD = 12, C_DEN = 13, C_ASTART = 14, C_DARM = 15;
    // input select fields, 3 bits each
    localparam int I_CONV = 0, I_GATE = 3, I_ATB = 6, I_DTRG = 9, I_DUPD = 12, I_DTB = 15;
    localparam logic [17:0] INSEL_RST  = 18'h03828;
    localparam logic [8:0]  OUTSEL_RST = 9'h1DD;
    localparam logic [15:0] CTRL_RST   = 16'h0001;
    localparam logic [7:0]  SLEN_RST   = 8'h01;
    // counter config, 8 bits per counter
    localparam int K_SRC = 0, K_CPOL = 2, K_GPOL = 3, K_MODE2 = 4;
    localparam logic [1:0] SRC_FAST = 2'h0, SRC_SLOW = 2'h1;

    typedef enum logic [2:0] {
        OS_SCAN_BEGIN = 3'h0, OS_SCAN_HOLD = 3'h1, OS_ACQ_DONE = 3'h2, OS_CONVERT = 3'h3,
        OS_DAC_TRIG = 3'h4, OS_DAC_UPD = 3'h5, OS_LOW = 3'h6
    } dtr_osel_t;

    typedef enum logic [2:0] {
        AS_OFF = 3'b001, AS_WAIT = 3'b010, AS_SCAN = 3'b100
    } dtr_adc_st_t;

    typedef enum logic [2:0] {
        DS_OFF = 3'b001, DS_ARMED = 3'b010, DS_RUN = 3'b100
    } dtr_dac_st_t;
endpackage

/* File: verif/dtr_router_sva.sv */
`timescale 1ns/1ps
module dtr_router_sva #(
    parameter int N_AUX_OUT = 3
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o,
    input wire logic [31:0]          wb_dat_o,
    input wire logic [N_AUX_OUT-1:0] aux_output_pin_o,
    input wire logic                 adc_convert_o,
    input wire logic                 dac_update_o,
    input wire logic                 counter_one_output_o,
    input wire logic                 counter_two_output_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("acknowledge without request");
    // a held level would start a second conversion
    a_conv_single: assert property (adc_convert_o |=> !adc_convert_o)
        else $error("convert pulse wider than one cycle");
    a_upd_single: assert property (dac_update_o |=> !dac_update_o)
        else $error("update pulse wider than one cycle");
    a_reset_pins: assert property ($fell(rst_i) |->
        aux_output_pin_o == '0 && !adc_convert_o && !dac_update_o)
        else $error("pins not quiet after reset");
    a_reset_bus: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0)
        else $error("bus outputs not cleared by reset");
    a_reset_ctr: assert property ($fell(rst_i) |->
        !counter_one_output_o && !counter_two_output_o)
        else $error("counter outputs not cleared by reset");
endmodule

bind dtr_router dtr_router_sva #(.N_AUX_OUT(N_AUX_OUT)) sva_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .aux_output_pin_o(aux_output_pin_o),
    .adc_convert_o(adc_convert_o),
    .dac_update_o(dac_update_o),
    .counter_one_output_o(counter_one_output_o),
    .counter_two_output_o(counter_two_output_o)
);

/* File: verif/dtr_far_model.sv */
`timescale 1ns/1ps
module dtr_far_model #(
    parameter int CONV_GAP = 200,
    parameter int UPD_GAP  = 4000
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [5:0] aux_lvl_i,
    input  wire logic       ctr_run_i,
    input  wire logic [1:0] gate_lvl_i,
    output logic      [5:0] aux_o,
    output logic      [1:0] ctr_clk_o,
    output logic      [1:0] gate_o
);
    int   gap_q;
    logic div_q;
    assign gate_o = gate_lvl_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_o <= 6'h00;
            gap_q <= 0;
            div_q <= 1'b0;
            ctr_clk_o <= 2'h0;
        end else begin
            gap_q <= gap_q + 1;
            if (aux_lvl_i !== aux_o &&
                gap_q >= ((aux_lvl_i[3] !== aux_o[3]) ? UPD_GAP : CONV_GAP)) begin
                aux_o <= aux_lvl_i;
                gap_q <= 0;
            end
            // 10 MHz pin clock, 50 ns phases, still when idle
            if (ctr_run_i) begin
                div_q <= ~div_q;
                if (div_q)
                    ctr_clk_o <= ~ctr_clk_o;
            end
        end
    end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, adc_convert_o, dac_update_o;
    logic        ctr_run, c1_o, c2_o;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rdat, v, w;
    logic [5:0]  aux_lvl, aux_pin;
    logic [2:0]  aux_out;
    logic [1:0]  gate_lvl, ctr_clk, gate;
    logic [6:0]  obs;
    int          err_count, num_checks, seed, n1, n2;
    int          pul [7];
    int          hi [7];
    logic [7:0]  ofs [6] = '{dtr_pkg::OFS_CTRL, dtr_pkg::OFS_INSEL, dtr_pkg::OFS_OUTSEL,
                             dtr_pkg::OFS_SLEN, dtr_pkg::OFS_STAT, 8'h3C};
    logic [31:0] rexp [6] = '{32'(dtr_pkg::CTRL_RST), 32'(dtr_pkg::INSEL_RST),
                              32'(dtr_pkg::OUTSEL_RST), 32'(dtr_pkg::SLEN_RST), 32'h90, 32'h0};
    assign obs = {c2_o, c1_o, dac_update_o, adc_convert_o, aux_out};

    dtr_router dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .aux_input_pin_i({aux_pin[5:3], ctr_clk[0], aux_pin[1:0]}), // timebase on pin 2
        .counter_one_clock_in_i(ctr_clk[0]), .counter_one_gate_in_i(gate[0]),
        .counter_two_clock_in_i(ctr_clk[1]), .counter_two_gate_in_i(gate[1]),
        .aux_output_pin_o(aux_out), .adc_convert_o(adc_convert_o),
        .dac_update_o(dac_update_o), .counter_one_output_o(c1_o), .counter_two_output_o(c2_o));
    dtr_far_model far_u (.clk_i(clk_i), .rst_i(rst_i), .aux_lvl_i(aux_lvl), .ctr_run_i(ctr_run),
        .gate_lvl_i(gate_lvl), .aux_o(aux_pin), .ctr_clk_o(ctr_clk), .gate_o(gate));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        // ack seen exactly at the second edge
        chk("wb_ack_lat", 32'd2, 32'(n));
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // pulses counted as rising edges, widths as high cycles
    task automatic watch(input int n);
        logic [6:0] prev;
        prev = obs;
        pul = '{default: 0};
        hi = '{default: 0};
        repeat (n) begin
            @(posedge clk_i);
            for (int i = 0; i < 7; i++) begin
                if (obs[i] === 1'b1 && prev[i] !== 1'b1)
                    pul[i]++;
                if (obs[i] === 1'b1)
                    hi[i]++;
            end
            prev = obs;
        end
    endtask

    task automatic astep(input logic [5:0] p, input int ec, input int eb, input int ed);
        aux_lvl <= p;
        watch(300);
        chk("convert", ec, pul[3]);
        chk("convert_hi", ec, hi[3]);
        chk("scan_begin", eb, pul[0]);
        chk("begin_hi", 2 * eb, hi[0]);
        chk("scan_hold", eb, pul[1]);
        chk("acq_done", ed, pul[2]);
        chk("done_hi", 2 * ed, hi[2]);
    endtask

    task automatic dstep(input logic [5:0] p, input int eu, input int et, input logic inv);
        aux_lvl <= p;
        watch(4100);
        chk("dac_update", eu, pul[4]);
        chk("update_hi", eu, hi[4]);
        chk("trig_out", et, pul[0]);
        chk("trig_hi", 2 * et, hi[0]);
        chk("upd_out", eu, pul[1]);
        chk("upd_out_hi", inv ? 4100 - 9 * eu : 9 * eu, hi[1]);
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end

    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = {1'b1, 47'h0};
        {aux_lvl, ctr_run, gate_lvl, err_count, num_checks, seed} = {9'h0, 64'h0, 32'd52553};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ofs[i], 32'h0, 4'hF);
            chk("reg_reset", rexp[i], rdat);
        end
        bus(1'b1, dtr_pkg::OFS_STAT, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
        for (int i = 4; i < 6; i++) begin
            bus(1'b0, ofs[i], 32'h0, 4'hF);
            chk("reg_ro", rexp[i], rdat);
        end
        v = $random(seed);
        w = $random(seed);
        bus(1'b1, dtr_pkg::OFS_INSEL, v, 4'hF);
        bus(1'b1, dtr_pkg::OFS_INSEL, w, 4'h1);
        bus(1'b0, dtr_pkg::OFS_INSEL, 32'h0, 4'hF);
        chk("insel_sel", {14'h0, v[17:8], w[7:0]}, rdat);
        bus(1'b1, dtr_pkg::OFS_INSEL, 32'(dtr_pkg::INSEL_RST), 4'hF);
        bus(1'b1, dtr_pkg::OFS_SLEN, 32'h1, 4'hF);
        bus(1'b1, dtr_pkg::OFS_SCNT, 32'h2, 4'hF);
        bus(1'b1, dtr_pkg::OFS_OUTSEL, 32'h088, 4'hF);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'h4003, 4'hF);
        astep(6'h01, 1, 1, 0);
        astep(6'h00, 0, 0, 0);
        astep(6'h01, 1, 1, 1);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'h4003, 4'hF);
        astep(6'h21, 0, 0, 0);
        astep(6'h20, 0, 0, 0);
        astep(6'h21, 0, 0, 0);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'h4007, 4'hF);
        astep(6'h01, 0, 0, 0);
        astep(6'h00, 1, 1, 0);
        bus(1'b1, dtr_pkg::OFS_OUTSEL, 32'h1AC, 4'hF);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'hB000, 4'hF);
        dstep(6'h08, 0, 0, 1'b0);
        dstep(6'h18, 0, 1, 1'b0);
        dstep(6'h10, 0, 0, 1'b0);
        dstep(6'h18, 1, 0, 1'b0);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'h3480, 4'hF);
        dstep(6'h10, 1, 0, 1'b1);
        ctr_run <= 1'b1;
        bus(1'b1, dtr_pkg::OFS_OUTSEL, 32'h088, 4'hF);
        astep(6'h20, 0, 0, 0);
        n1 = 2 + $unsigned($random(seed)) % 6;
        bus(1'b1, dtr_pkg::OFS_SLEN, 32'h3, 4'hF);
        bus(1'b1, dtr_pkg::OFS_ADIV, 32'(n1), 4'hF);
        bus(1'b1, dtr_pkg::OFS_INSEL, 32'(dtr_pkg::INSEL_RST) | 32'h0000_0080, 4'hF);
        bus(1'b1, dtr_pkg::OFS_CTRL, 32'h0011, 4'hF);
        astep(6'h00, 3, 1, 1);
        gate_lvl <= 2'h2;
        n1 = 2 + $unsigned($random(seed)) % 8;
        n2 = 2 + $unsigned($random(seed)) % 8;
        bus(1'b1, dtr_pkg::OFS_CCFG, 32'h0000_0200, 4'hF);
        bus(1'b1, dtr_pkg::OFS_CLOAD, {16'(n2), 16'(n1)}, 4'h5);
        watch(120);
        chk("ctr1_gated", 0, pul[5]);
        chk("counter_two_output", 1, pul[6]);
        gate_lvl <= 2'h3;
        watch(120);
        chk("counter_one_output", 1, pul[5]);
        bus(1'b0, dtr_pkg::OFS_CLATCH, 32'h0, 4'hF);
        chk("ctr_latch", {16'h0, 16'(n1)}, rdat);
        bus(1'b1, dtr_pkg::OFS_CCFG, 32'h0000_1200, 4'hF);
        bus(1'b1, dtr_pkg::OFS_CLOAD, {16'(n2), 16'h0}, 4'hC);
        // window of eight whole periods of the rate generator
        watch(32 * n2);
        chk("ctr2_rate", 8, pul[6]);
        print_verdict();
    end
endmodule
